// ==== rtl/rsi_params.svh ====
// Constants of the reset state initialiser: offsets, reset values, masks.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
// How it works
// - Each event is sorted into power-on, reset group or wake-up class.
// - An enabled interrupt wake-up saves the PC on top of the stack.
// - That same wake-up loads the PC with vector 0008h or 0018h.
// - A wake-up leaves a flag bit set that names its source.
// - Unused bits read zero, u bits keep, q bits follow the cause.
// - Timer zero control goes to all ones on both resets, kept on wake.
// - Timer zero high buffer clears on power-on only.
// - Oscillator control loads 0110 q000; wake-up updates only bit 3.
// - Reset cause control loads 0111 11qq, 0uqq qquu or uuuu qquu.
// - Timer two period goes to all ones, its count to zero, on resets.
// - Serial two transmit status loads 0000 0010 on both resets.
// - Analog channel configs go to all ones on power-on only.
// - Watchdog control loads 0-x0 -000 on resets, kept on wake.
`ifndef RSI_PARAMS_SVH
`define RSI_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RSI_OFF_T0CTL 8'h00
`define RSI_OFF_T0HB 8'h04
`define RSI_OFF_OSC 8'h08
`define RSI_OFF_RCC 8'h0C
`define RSI_OFF_T2PER 8'h10
`define RSI_OFF_T2CNT 8'h14
`define RSI_OFF_TX2 8'h18
`define RSI_OFF_AN0 8'h1C
`define RSI_OFF_AN1 8'h20
`define RSI_OFF_AN2 8'h24
`define RSI_OFF_WDC 8'h28
`define RSI_OFF_WAKE 8'h2C
`define RSI_OFF_TOS 8'h30
`define RSI_OFF_SP 8'h34
`define RSI_OFF_PC 8'h38
`define RSI_OFF_CLS 8'h3C
`define RSI_OFF_STS 8'h40
`define RSI_OFF_MSK 8'h44

// ---------------------------------------------------------------
// Reset values and bit masks
// ---------------------------------------------------------------
`define RSI_T0CTL_RST 8'hFF
`define RSI_T0HB_RST 8'h00
`define RSI_OSC_RST 8'h60
`define RSI_OSC_QBIT 3
`define RSI_OSC_WMASK 8'hF7
`define RSI_RCC_POR 8'h7C
`define RSI_RCC_POR_Q 8'h03
`define RSI_RCC_GRP_Q 8'h3C
`define RSI_RCC_GRP_U 8'h43
`define RSI_RCC_WAKE_Q 8'h0C
`define RSI_T2PER_RST 8'hFF
`define RSI_T2CNT_RST 8'h00
`define RSI_TX2_RST 8'h02
`define RSI_AN_RST 8'hFF
`define RSI_WDC_RST 8'h00
`define RSI_WDC_IMPL 8'hB7
`define RSI_WDC_XBIT 8'h20
`define RSI_VEC_RESET 21'h0_0000
`define RSI_VEC_HIGH 21'h0_0008
`define RSI_VEC_LOW 21'h0_0018
`define RSI_STK_W 5
`define RSI_PC_W 21

`endif

// ==== rtl/rsi_pkg.sv ====
// Types of the reset state initialiser.
// Assumes rsi_params.svh is compiled alongside.
`include "rsi_params.svh"
package rsi_pkg;

  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_POR,
    CLS_GRP,
    CLS_WAKE
  } rsi_class_t;

  // Cause inputs: one per reset or wake source, plus irq qualifiers and q values
  typedef struct packed {
    logic por_bor;
    logic external_clear_pin;
    logic watchdog_timer;
    logic reset_instr;
    logic stack_reset;
    logic mismatch_reset;
    logic wake_watchdog;
    logic wake_irq;
    logic irq_is_high;
    logic high_prio_global_irq_enable;
    logic low_prio_global_irq_enable;
    logic osc_q;
    logic [7:0] rcc_q;
  } rsi_cause_t;

  typedef struct packed {
    logic [7:0] timer_zero_control;
    logic [7:0] timer_zero_high_buffer;
    logic [7:0] oscillator_control;
    logic [7:0] reset_cause_control;
    logic [7:0] timer_two_period;
    logic [7:0] timer_two_count;
    logic [7:0] serial_two_tx_status;
    logic [2:0][7:0] analog_channel_config;
    logic [7:0] watchdog_control;
  } rsi_sfr_t;

  typedef struct packed {
    rsi_sfr_t sfr;
    logic [7:0] wake_flag;
    logic [`RSI_PC_W-1:0] stack_top;
    logic [`RSI_STK_W-1:0] stack_pointer_reg;
    logic [`RSI_PC_W-1:0] pc;
    rsi_class_t cls;
    logic [3:0] sts;
    logic [3:0] msk;
    logic ack;
    logic [31:0] rdata;
  } rsi_state_t;

endpackage

// ==== rtl/rsi_top.sv ====
// Reset state initialiser: sets special-function registers by reset class.
// Assumes cause inputs are one-cycle pulses synchronous to clk.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "rsi_params.svh"
module rsi_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire rsi_pkg::rsi_cause_t cause,
  input wire logic [`RSI_PC_W-1:0] pc_in,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  output rsi_pkg::rsi_sfr_t sfr,
  output logic [`RSI_PC_W-1:0] pc_out,
  output logic [`RSI_PC_W-1:0] stack_top,
  output logic [`RSI_STK_W-1:0] stack_pointer_reg
);

  // ---------------------------------------------------------------
  // Power-on values, also taken on rstn
  // ---------------------------------------------------------------
  localparam rsi_pkg::rsi_sfr_t SFR_POR = '{
    timer_zero_control: `RSI_T0CTL_RST,
    timer_zero_high_buffer: `RSI_T0HB_RST,
    oscillator_control: `RSI_OSC_RST,
    reset_cause_control: `RSI_RCC_POR,
    timer_two_period: `RSI_T2PER_RST,
    timer_two_count: `RSI_T2CNT_RST,
    serial_two_tx_status: `RSI_TX2_RST,
    analog_channel_config: {3{`RSI_AN_RST}},
    watchdog_control: `RSI_WDC_RST
  };

  localparam rsi_pkg::rsi_state_t ST_RST = '{
    sfr: SFR_POR,
    wake_flag: 8'h00,
    stack_top: `RSI_VEC_RESET,
    stack_pointer_reg: '0,
    pc: `RSI_VEC_RESET,
    cls: rsi_pkg::CLS_NONE,
    sts: 4'h0,
    msk: 4'h0,
    ack: 1'b0,
    rdata: 32'h0000_0000
  };

  // ---------------------------------------------------------------
  // State and working signals
  // ---------------------------------------------------------------
  rsi_pkg::rsi_state_t s_q;
  rsi_pkg::rsi_state_t s_d;
  logic req;
  logic take;
  logic wr8;
  logic grp;
  logic wake;
  logic vec;
  logic [3:0] ev;
  logic [31:0] rd;
  logic [7:0] wd;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ev = 4'h0;
    req = read | write;
    take = req & s_q.ack;
    wr8 = take & write & byteenable[0];
    wd = writedata[7:0];
    grp = cause.external_clear_pin | cause.watchdog_timer |
          cause.reset_instr | cause.stack_reset |
          cause.mismatch_reset;
    wake = cause.wake_watchdog | cause.wake_irq;
    vec = cause.wake_irq & (cause.high_prio_global_irq_enable |
          cause.low_prio_global_irq_enable);

    // Read mux; unmapped words and unused bits read zero
    rd = 32'h0000_0000;
    unique case ({2'b00, address[7:2]})
      `RSI_OFF_T0CTL >> 2: rd[7:0] = s_q.sfr.timer_zero_control;
      `RSI_OFF_T0HB >> 2: rd[7:0] = s_q.sfr.timer_zero_high_buffer;
      `RSI_OFF_OSC >> 2: rd[7:0] = s_q.sfr.oscillator_control;
      `RSI_OFF_RCC >> 2: rd[7:0] = s_q.sfr.reset_cause_control;
      `RSI_OFF_T2PER >> 2: rd[7:0] = s_q.sfr.timer_two_period;
      `RSI_OFF_T2CNT >> 2: rd[7:0] = s_q.sfr.timer_two_count;
      `RSI_OFF_TX2 >> 2: rd[7:0] = s_q.sfr.serial_two_tx_status;
      `RSI_OFF_AN0 >> 2: rd[7:0] = s_q.sfr.analog_channel_config[0];
      `RSI_OFF_AN1 >> 2: rd[7:0] = s_q.sfr.analog_channel_config[1];
      `RSI_OFF_AN2 >> 2: rd[7:0] = s_q.sfr.analog_channel_config[2];
      `RSI_OFF_WDC >> 2:
        rd[7:0] = s_q.sfr.watchdog_control & `RSI_WDC_IMPL;
      `RSI_OFF_WAKE >> 2: rd[7:0] = s_q.wake_flag;
      `RSI_OFF_TOS >> 2: rd[`RSI_PC_W-1:0] = s_q.stack_top;
      `RSI_OFF_SP >> 2: rd[`RSI_STK_W-1:0] = s_q.stack_pointer_reg;
      `RSI_OFF_PC >> 2: rd[`RSI_PC_W-1:0] = s_q.pc;
      `RSI_OFF_CLS >> 2: rd[1:0] = s_q.cls;
      `RSI_OFF_STS >> 2: rd[3:0] = s_q.sts;
      `RSI_OFF_MSK >> 2: rd[3:0] = s_q.msk;
      default: rd = 32'h0000_0000;
    endcase

    // Bus: one wait cycle, answer on the second edge
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack & read) begin
      s_d.rdata = rd;
    end

    // Software writes, lane 0 only
    if (wr8) begin
      unique case ({2'b00, address[7:2]})
        `RSI_OFF_T0CTL >> 2: s_d.sfr.timer_zero_control = wd;
        `RSI_OFF_T0HB >> 2: s_d.sfr.timer_zero_high_buffer = wd;
        `RSI_OFF_OSC >> 2: begin
          s_d.sfr.oscillator_control =
            (wd & `RSI_OSC_WMASK) |
            (s_q.sfr.oscillator_control & ~`RSI_OSC_WMASK);
        end
        `RSI_OFF_RCC >> 2: s_d.sfr.reset_cause_control = wd;
        `RSI_OFF_T2PER >> 2: s_d.sfr.timer_two_period = wd;
        `RSI_OFF_T2CNT >> 2: s_d.sfr.timer_two_count = wd;
        `RSI_OFF_TX2 >> 2: s_d.sfr.serial_two_tx_status = wd;
        `RSI_OFF_AN0 >> 2: s_d.sfr.analog_channel_config[0] = wd;
        `RSI_OFF_AN1 >> 2: s_d.sfr.analog_channel_config[1] = wd;
        `RSI_OFF_AN2 >> 2: s_d.sfr.analog_channel_config[2] = wd;
        `RSI_OFF_WDC >> 2: begin
          s_d.sfr.watchdog_control = wd & `RSI_WDC_IMPL;
        end
        `RSI_OFF_WAKE >> 2: s_d.wake_flag = wd;
        `RSI_OFF_MSK >> 2: s_d.msk = wd[3:0];
        default: s_d.msk = s_d.msk;
      endcase
    end

    // Status clears when read, only the bits the read returned, so an
    // event between data capture and clear is not lost
    if (take & read & ({2'b00, address[7:2]} == (`RSI_OFF_STS >> 2))) begin
      s_d.sts = s_q.sts & ~s_q.rdata[3:0];
    end

    // -------------------------------------------------------------
    // Events; power-on first, then reset group, then wake
    // -------------------------------------------------------------
    if (cause.por_bor) begin
      s_d.cls = rsi_pkg::CLS_POR;
      ev[0] = 1'b1;
      s_d.sfr.timer_zero_control = `RSI_T0CTL_RST;
      s_d.sfr.timer_zero_high_buffer = `RSI_T0HB_RST;
      s_d.sfr.oscillator_control = `RSI_OSC_RST;
      s_d.sfr.oscillator_control[`RSI_OSC_QBIT] = cause.osc_q;
      s_d.sfr.reset_cause_control =
        `RSI_RCC_POR | (cause.rcc_q & `RSI_RCC_POR_Q);
      s_d.sfr.timer_two_period = `RSI_T2PER_RST;
      s_d.sfr.timer_two_count = `RSI_T2CNT_RST;
      s_d.sfr.serial_two_tx_status = `RSI_TX2_RST;
      s_d.sfr.analog_channel_config = {3{`RSI_AN_RST}};
      s_d.sfr.watchdog_control =
        `RSI_WDC_RST | (s_q.sfr.watchdog_control & `RSI_WDC_XBIT);
      s_d.wake_flag = 8'h00;
      s_d.stack_pointer_reg = '0;
      s_d.pc = `RSI_VEC_RESET;
    end else if (grp) begin
      s_d.cls = rsi_pkg::CLS_GRP;
      ev[1] = 1'b1;
      s_d.sfr.timer_zero_control = `RSI_T0CTL_RST;
      s_d.sfr.oscillator_control = `RSI_OSC_RST;
      s_d.sfr.oscillator_control[`RSI_OSC_QBIT] = cause.osc_q;
      s_d.sfr.reset_cause_control =
        (cause.rcc_q & `RSI_RCC_GRP_Q) |
        (s_q.sfr.reset_cause_control & `RSI_RCC_GRP_U);
      s_d.sfr.timer_two_period = `RSI_T2PER_RST;
      s_d.sfr.timer_two_count = `RSI_T2CNT_RST;
      s_d.sfr.serial_two_tx_status = `RSI_TX2_RST;
      s_d.sfr.watchdog_control =
        `RSI_WDC_RST | (s_q.sfr.watchdog_control & `RSI_WDC_XBIT);
      s_d.wake_flag = 8'h00;
      s_d.stack_pointer_reg = '0;
      s_d.pc = `RSI_VEC_RESET;
    end else if (wake) begin
      s_d.cls = rsi_pkg::CLS_WAKE;
      ev[2] = 1'b1;
      // Only the SFR q bits move; every other SFR bit is kept
      s_d.sfr.oscillator_control[`RSI_OSC_QBIT] = cause.osc_q;
      s_d.sfr.reset_cause_control =
        (cause.rcc_q & `RSI_RCC_WAKE_Q) |
        (s_q.sfr.reset_cause_control & ~`RSI_RCC_WAKE_Q);
      // Source flag survives a same-cycle software write
      s_d.wake_flag[0] = s_d.wake_flag[0] | cause.wake_watchdog;
      s_d.wake_flag[1] = s_d.wake_flag[1] |
                         (cause.wake_irq & cause.irq_is_high);
      s_d.wake_flag[2] = s_d.wake_flag[2] |
                         (cause.wake_irq & ~cause.irq_is_high);
      if (vec) begin
        ev[3] = 1'b1;
        s_d.stack_top = pc_in;
        s_d.stack_pointer_reg = s_q.stack_pointer_reg +
                                `RSI_STK_W'(1);
        s_d.pc = cause.irq_is_high ? `RSI_VEC_HIGH
                                   : `RSI_VEC_LOW;
      end
    end

    // Hardware set wins over read clear
    s_d.sts = s_d.sts | ev;

    if (!ce) begin
      s_d = s_q;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // No access completes while ce holds the state frozen
  assign waitrequest = req & ~(s_q.ack & ce);
  assign readdata = s_q.rdata;
  assign irq = |(s_q.sts & s_q.msk);
  assign sfr = s_q.sfr;
  assign pc_out = s_q.pc;
  assign stack_top = s_q.stack_top;
  assign stack_pointer_reg = s_q.stack_pointer_reg;

endmodule

// ==== verification/rsi_reset_checker.sv ====
// Concurrent checks on the reset state initialiser outputs.
// Assumes a bind onto rsi_top; sees only that module's ports.
`timescale 1ns/1ps
`include "rsi_params.svh"
module rsi_reset_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire rsi_pkg::rsi_cause_t cause,
  input wire logic [`RSI_PC_W-1:0] pc_in,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire rsi_pkg::rsi_sfr_t sfr,
  input wire logic [`RSI_PC_W-1:0] pc_out,
  input wire logic [`RSI_PC_W-1:0] stack_top,
  input wire logic [`RSI_STK_W-1:0] stack_pointer_reg
);
  // ---------------------------------------------------------------
  // Event classes seen at the cause inputs
  // ---------------------------------------------------------------
  logic rg, por, grp, wk, vec;
  assign rg = cause.external_clear_pin | cause.watchdog_timer |
    cause.reset_instr | cause.stack_reset | cause.mismatch_reset;
  assign por = ce & cause.por_bor;
  assign grp = ce & ~cause.por_bor & rg;
  assign wk = ce & ~cause.por_bor & ~rg &
    (cause.wake_watchdog | cause.wake_irq);
  assign vec = wk & cause.wake_irq & (cause.high_prio_global_irq_enable |
    cause.low_prio_global_irq_enable);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_por_values:
    assert property (por |=> sfr.timer_zero_control == 8'hFF &&
      sfr.timer_zero_high_buffer == 8'h00 && sfr.analog_channel_config == '1)
    else $error("power-on values wrong");
  a_por_cause_bits:
    assert property (por |=> sfr.reset_cause_control ==
      (8'h7C | ($past(cause.rcc_q) & 8'h03)))
    else $error("power-on cause bits wrong");
  a_reset_common:
    assert property (por || grp |=> sfr.oscillator_control ==
      {4'h6, $past(cause.osc_q), 3'h0} && sfr.timer_two_period == 8'hFF &&
      sfr.timer_two_count == 8'h00 && sfr.serial_two_tx_status == 8'h02 &&
      (sfr.watchdog_control & 8'hDF) == 8'h00)
    else $error("reset class values wrong");
  a_group_keeps:
    assert property (grp |=> $stable(sfr.timer_zero_high_buffer) &&
      $stable(sfr.analog_channel_config))
    else $error("group reset changed kept bits");
  a_wake_keeps:
    assert property (wk |=> $stable(sfr.timer_zero_control) &&
      $stable(sfr.timer_two_period) && $stable(sfr.serial_two_tx_status))
    else $error("wake-up changed kept bits");
  a_wake_vector:
    assert property (vec |=> pc_out == ($past(cause.irq_is_high) ?
      `RSI_VEC_HIGH : `RSI_VEC_LOW))
    else $error("wake-up vector wrong");
  a_wake_push:
    assert property (vec |=> stack_top == $past(pc_in) &&
      stack_pointer_reg == $past(stack_pointer_reg) + 5'd1)
    else $error("stack push wrong");
  a_bus_one_wait:
    assert property (ce && (read || write) && waitrequest |=> !waitrequest)
    else $error("bus wait too long");
  c_vectored: cover property (vec);
  c_por_and_group: cover property (por && rg);
  c_bus_done: cover property ((read || write) && !waitrequest);
endmodule

// ==== verification/tb_rsi_top.sv ====
// Self-checking bench of the reset state initialiser, with a register model.
// Assumes rsi_top and rsi_reset_checker are compiled before it.
`timescale 1ns/1ps
`include "rsi_params.svh"
module tb_rsi_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic waitrequest, irq;
  rsi_pkg::rsi_cause_t cause = '0;
  rsi_pkg::rsi_sfr_t sfr;
  logic [`RSI_PC_W-1:0] pc_in = '0;
  logic [`RSI_PC_W-1:0] pc_out, stack_top;
  logic [`RSI_STK_W-1:0] stack_pointer_reg;
  logic [7:0] address = 8'h00;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata, rd;
  logic [7:0] m [11];
  int fails = 0;
  int comparisons = 0;
  int seed = 32'h523f;
  int sp = 0;
  always #2 clk = ~clk;
  rsi_top i_dut (.clk(clk), .rstn(rstn), .ce(ce), .cause(cause),
    .pc_in(pc_in), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .sfr(sfr), .pc_out(pc_out),
    .stack_top(stack_top), .stack_pointer_reg(stack_pointer_reg));
  // ---------------------------------------------------------------
  // Bus, event and compare tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic rst_dut();
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    m = '{8'hFF, 8'h00, 8'h60, 8'h7C, 8'hFF, 8'h00, 8'h02, 8'hFF, 8'hFF,
      8'hFF, 8'h00};
    sp = 0;
  endtask
  task automatic check_all();
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, 8'(i * 4), 8'h00);
      check(rd, {24'h00_0000, m[i]});
    end
  endtask
  task automatic ev(input rsi_pkg::rsi_cause_t c);
    logic [7:0] q;
    logic [`RSI_PC_W-1:0] p;
    logic rg;
    q = {4'h0, c.osc_q, 3'h0};
    p = `RSI_PC_W'($random(seed));
    rg = c.external_clear_pin | c.watchdog_timer | c.reset_instr |
      c.stack_reset | c.mismatch_reset;
    cause <= c;
    pc_in <= p;
    @(posedge clk);
    cause <= '0;
    @(posedge clk);
    if (c.por_bor || rg) begin
      m[0] = 8'hFF;
      m[2] = 8'h60 | q;
      m[3] = c.por_bor ? 8'h7C | (c.rcc_q & 8'h03) :
        (m[3] & 8'h43) | (c.rcc_q & 8'h3C);
      m[4] = 8'hFF;
      m[5] = 8'h00;
      m[6] = 8'h02;
      m[10] = m[10] & 8'h20;
      sp = 0;
      if (c.por_bor) begin
        m[1] = 8'h00;
        m[7] = 8'hFF;
        m[8] = 8'hFF;
        m[9] = 8'hFF;
      end
    end else begin
      m[2] = (m[2] & 8'hF7) | q;
      m[3] = (m[3] & 8'hF3) | (c.rcc_q & 8'h0C);
      if (c.wake_irq && (c.high_prio_global_irq_enable ||
          c.low_prio_global_irq_enable)) begin
        sp = (sp + 1) % 32;
        check(32'(pc_out), c.irq_is_high ? 32'h8 : 32'h18);
        check(32'(stack_top), 32'(p));
      end
    end
    check(32'(stack_pointer_reg), 32'(sp));
  endtask
  initial begin
    rsi_pkg::rsi_cause_t c;
    logic [7:0] d;
    rst_dut();
    check_all();
    // Each pass: random writes, then one event class (all three at once in the last pass), then full readback
    for (int k = 0; k < 11; k++) begin
      for (int i = 0; i < 11; i++) begin
        d = 8'($random(seed));
        bus(1'b1, 8'(i * 4), d);
        if (i == 2) d = (d & 8'hF7) | (m[2] & 8'h08);
        m[i] = (i == 10) ? d & 8'hB7 : d;
      end
      c = '0;
      c.osc_q = 1'($random(seed));
      c.rcc_q = 8'($random(seed));
      c[19 - (k > 7 ? 7 : k)] = 1'b1;
      c.irq_is_high = (k == 7);
      c.high_prio_global_irq_enable = (k == 7);
      c.low_prio_global_irq_enable = (k == 8);
      c.por_bor = c.por_bor | (k == 10);
      c.external_clear_pin = c.external_clear_pin | (k == 10);
      ev(c);
      check_all();
      $display("test %0d done", k);
    end
    bus(1'b1, 8'h44, 8'h04);
    bus(1'b0, 8'h40, 8'h00);
    check(32'(irq), 32'h0);
    c = '0;
    c.wake_watchdog = 1'b1;
    ev(c);
    check(32'(irq), 32'h1);
    bus(1'b0, 8'h40, 8'h00);
    check(rd, 32'h4);
    check(32'(irq), 32'h0);
    bus(1'b0, 8'h2C, 8'h00);
    check(rd, 32'h1);
    // Lane-masked write is ignored; a pulse while ce is low changes nothing
    d = 8'($random(seed)) | 8'h01;
    bus(1'b1, 8'h04, d);
    m[1] = d;
    byteenable <= 4'h0;
    bus(1'b1, 8'h04, 8'h00);
    byteenable <= 4'h1;
    ce <= 1'b0;
    c = '0;
    c.por_bor = 1'b1;
    cause <= c;
    @(posedge clk);
    cause <= '0;
    ce <= 1'b1;
    @(posedge clk);
    check(32'(sfr.timer_zero_high_buffer), 32'(m[1]));
    bus(1'b0, 8'h40, 8'h00);
    check(rd, 32'h0);
    $display("test enable done");
    bus(1'b0, 8'hFC, 8'h00);
    check(rd, 32'h0);
    rst_dut();
    check_all();
    $display("test irq and reset done");
    print_verdict();
  end
endmodule
bind rsi_top rsi_reset_checker i_chk (.clk(clk), .rstn(rstn), .ce(ce),
  .cause(cause), .pc_in(pc_in), .read(read), .write(write),
  .waitrequest(waitrequest), .sfr(sfr), .pc_out(pc_out),
  .stack_top(stack_top), .stack_pointer_reg(stack_pointer_reg));
